/* hdl/disc_write_fault_detector.sv */
// Read/write fault supervisor: latches write faults, drives indicators and unload request
// Summary of operation
// - Latch off-cylinder fault when writing, heads unsettled, no fault latched.
// - Off-cylinder fault drives its indicator, nondestructive summary low, status bit 4.
// - Latch read-during-write fault when read gate active while writing, none latched.
// - Read-during-write fault drives its indicator, nondestructive summary low, status bit 5.
// - Nondestructive clear from power-on start, run switch, or clear command.
// - Any latched fault drives common fault line low and blocks further sets.
// - Each nondestructive fault also lights the drive fault lamp low.
// - Writing without AC current latches no-AC fault, indicator and destructive summary.
// - Multi-head select low latches multi-head fault, indicator and destructive summary.
// - Write current without write mode is a destructive fault.
// - Current-without-gate sets both no-AC and multi-head flip-flops.
// - Destructive faults request head unload; nondestructive ones do not.
// - Destructive flops clear only on power-on start or run switch.
// - Unload request is a level held while a destructive flop is set; the sequencer runs the steps.
`timescale 1ns/10ps
module disc_write_fault_detector
  import write_fault_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Monitored conditions
  input wire monitor_s mon_i,
  // Clear sources
  input wire logic power_on_sequence_start_i,
  input wire logic run_switch_run_i,
  input wire logic clear_fault_command_i,
  // Indicator lines
  output indicators_s ind_o,
  output logic [STAT_WIDTH-1:0] fault_status_o,
  // Head unload request to the sequencer
  output logic head_retract_request_o
);

  // Whole module state
  typedef struct packed {
    fault_flops_s flt;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic nondestructive_clear;
  logic destructive_clear;
  logic any_fault;
  logic set_off_cyl;
  logic set_rd_wr;
  logic set_no_ac;
  logic set_multi_head;
  logic current_without_gate_fault;

  // Clear decode
  assign nondestructive_clear = power_on_sequence_start_i | run_switch_run_i
                              | clear_fault_command_i;
  assign destructive_clear = power_on_sequence_start_i | run_switch_run_i;

  // Fault detection gated by the common fault line
  assign any_fault = |state_reg.flt;
  assign set_off_cyl = mon_i.write_mode & mon_i.heads_settled_n & ~any_fault;
  assign set_rd_wr = mon_i.write_mode & mon_i.read_gate_active & ~any_fault;
  assign current_without_gate_fault = mon_i.write_current_applied & ~mon_i.write_mode
                                    & ~any_fault;
  assign set_no_ac = (mon_i.write_mode & ~mon_i.ac_write_current_present & ~any_fault)
                   | current_without_gate_fault;
  assign set_multi_head = (~mon_i.multi_head_select_n & ~any_fault)
                        | current_without_gate_fault;

  // Next-state: clears win over sets
  always_comb begin
    state_next = state_reg;
    if (nondestructive_clear) begin
      state_next.flt.off_cyl = 1'h0;
      state_next.flt.rd_wr = 1'h0;
    end else begin
      if (set_off_cyl) begin
        state_next.flt.off_cyl = 1'h1;
      end
      if (set_rd_wr) begin
        state_next.flt.rd_wr = 1'h1;
      end
    end
    if (destructive_clear) begin
      state_next.flt.no_ac = 1'h0;
      state_next.flt.multi_head = 1'h0;
    end else begin
      if (set_no_ac) begin
        state_next.flt.no_ac = 1'h1;
      end
      if (set_multi_head) begin
        state_next.flt.multi_head = 1'h1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= '{flt: '{FAULT_RST, FAULT_RST, FAULT_RST, FAULT_RST}};
    end else begin
      state_reg <= state_next;
    end
  end

  // Indicator outputs straight from the latches
  always_comb begin
    ind_o.off_cyl_fault_ind_n = ~state_reg.flt.off_cyl;
    ind_o.rd_wr_fault_ind_n = ~state_reg.flt.rd_wr;
    ind_o.no_ac_fault_ind_n = ~state_reg.flt.no_ac;
    ind_o.multi_head_fault_ind_n = ~state_reg.flt.multi_head;
    ind_o.nondestructive_summary_n = ~(state_reg.flt.off_cyl | state_reg.flt.rd_wr);
    ind_o.destructive_summary_n = ~(state_reg.flt.no_ac | state_reg.flt.multi_head);
    ind_o.any_write_fault_n = ~any_fault;
    // Lamp lit by any latched fault; the unload request does not drive it
    ind_o.fault_lamp_n = ~any_fault;
  end

  // Status word and unload request
  always_comb begin
    fault_status_o = '0;
    fault_status_o[STAT_OFF_CYL_BIT] = state_reg.flt.off_cyl;
    fault_status_o[STAT_RD_WR_BIT] = state_reg.flt.rd_wr;
  end
  // Sequencer runs the ordered unload steps from this level
  assign head_retract_request_o = state_reg.flt.no_ac | state_reg.flt.multi_head;

  // Checks: a latched fault blocks every later set
  blocked_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    any_fault && !destructive_clear
      |=> $stable(state_reg.flt.no_ac) && $stable(state_reg.flt.multi_head))
    else $error("fault set while another latched");
  blocked_nd_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    any_fault && !nondestructive_clear
      |=> $stable(state_reg.flt.off_cyl) && $stable(state_reg.flt.rd_wr))
    else $error("nondestructive fault set while another latched");
  any_line_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ind_o.any_write_fault_n == (ind_o.nondestructive_summary_n
      && ind_o.destructive_summary_n))
    else $error("common fault line disagrees with summaries");

  // Nondestructive faults: indicator, summary, lamp and status bit
  off_cyl_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    set_off_cyl && !nondestructive_clear |=> !ind_o.off_cyl_fault_ind_n
      && fault_status_o[STAT_OFF_CYL_BIT] && !ind_o.fault_lamp_n)
    else $error("off-cylinder fault not latched");
  off_cyl_pins_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    mon_i.write_mode && mon_i.heads_settled_n && ind_o.any_write_fault_n
      && !nondestructive_clear |=> !ind_o.off_cyl_fault_ind_n)
    else $error("off-cylinder condition ignored");
  off_cyl_out_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !ind_o.off_cyl_fault_ind_n |-> fault_status_o[STAT_OFF_CYL_BIT]
      && !ind_o.nondestructive_summary_n && !ind_o.any_write_fault_n)
    else $error("off-cylinder outputs inconsistent");
  rd_wr_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    set_rd_wr && !nondestructive_clear |=> !ind_o.rd_wr_fault_ind_n
      && fault_status_o[STAT_RD_WR_BIT] && !ind_o.nondestructive_summary_n)
    else $error("read-during-write fault not latched");
  rd_wr_pins_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    mon_i.write_mode && mon_i.read_gate_active && ind_o.any_write_fault_n
      && !nondestructive_clear |=> !ind_o.rd_wr_fault_ind_n)
    else $error("read-during-write condition ignored");
  rd_wr_out_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !ind_o.rd_wr_fault_ind_n |-> fault_status_o[STAT_RD_WR_BIT]
      && !ind_o.nondestructive_summary_n && !ind_o.any_write_fault_n)
    else $error("read-during-write outputs inconsistent");
  nd_lamp_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !ind_o.nondestructive_summary_n |-> !ind_o.fault_lamp_n)
    else $error("lamp dark on nondestructive fault");
  nd_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    nondestructive_clear |=> ind_o.nondestructive_summary_n)
    else $error("nondestructive clear failed");

  // Destructive faults: indicators, summary and unload request
  no_ac_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    mon_i.write_mode && !mon_i.ac_write_current_present && !any_fault && !destructive_clear
      |=> !ind_o.no_ac_fault_ind_n)
    else $error("no-AC fault not latched");
  no_ac_out_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !ind_o.no_ac_fault_ind_n |-> !ind_o.destructive_summary_n && !ind_o.any_write_fault_n)
    else $error("no-AC outputs inconsistent");
  mh_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !mon_i.multi_head_select_n && !any_fault && !destructive_clear
      |=> head_retract_request_o && !ind_o.multi_head_fault_ind_n)
    else $error("multi-head fault not latched");
  mh_out_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !ind_o.multi_head_fault_ind_n |-> !ind_o.destructive_summary_n
      && !ind_o.any_write_fault_n)
    else $error("multi-head outputs inconsistent");
  cwg_pins_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    mon_i.write_current_applied && !mon_i.write_mode && ind_o.any_write_fault_n
      && !destructive_clear |=> !ind_o.destructive_summary_n && head_retract_request_o)
    else $error("current-without-gate not declared");
  cwg_both_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    current_without_gate_fault && !destructive_clear |=> !ind_o.no_ac_fault_ind_n
      && !ind_o.multi_head_fault_ind_n && !ind_o.destructive_summary_n)
    else $error("current-without-gate did not set both");
  d_unload_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !ind_o.destructive_summary_n |-> head_retract_request_o)
    else $error("no unload on destructive fault");
  nd_no_unload_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !ind_o.nondestructive_summary_n && ind_o.destructive_summary_n
      |-> !head_retract_request_o)
    else $error("unload on nondestructive fault");
  unload_lamp_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    head_retract_request_o |-> !ind_o.fault_lamp_n)
    else $error("unload without fault lamp");

  // Clears: command spares destructive flops, clears beat sets
  d_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clear_fault_command_i && !destructive_clear && head_retract_request_o
      |=> head_retract_request_o)
    else $error("clear command cleared destructive fault");
  clear_wins_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    destructive_clear |=> ind_o.destructive_summary_n && ind_o.nondestructive_summary_n
      && !head_retract_request_o)
    else $error("set beat the clear");

  // Scenarios
  off_cyl_c: cover property (@(posedge clk_sys_i) disable iff (rst_i) set_off_cyl);
  rd_wr_c: cover property (@(posedge clk_sys_i) disable iff (rst_i) set_rd_wr);
  cwg_c: cover property (@(posedge clk_sys_i) disable iff (rst_i) current_without_gate_fault);
  clr_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    head_retract_request_o ##1 destructive_clear);
  blk_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    !ind_o.any_write_fault_n && !mon_i.multi_head_select_n);

endmodule

/* hdl/write_fault_pkg.sv */
// Package with state layout and constants for the read/write fault supervisor
package write_fault_pkg;

  // Status bit positions for the drive fault status word
  localparam int STAT_OFF_CYL_BIT = 4;
  localparam int STAT_RD_WR_BIT = 5;
  localparam int STAT_WIDTH = 8;

  // Reset values of the fault latches
  localparam logic FAULT_RST = 1'h0;

  // Latched fault flip-flops
  typedef struct packed {
    logic off_cyl;
    logic rd_wr;
    logic no_ac;
    logic multi_head;
  } fault_flops_s;

  // Monitored drive conditions
  typedef struct packed {
    logic write_mode;
    logic heads_settled_n;
    logic read_gate_active;
    logic ac_write_current_present;
    logic multi_head_select_n;
    logic write_current_applied;
  } monitor_s;

  // Low-true indicator outputs
  typedef struct packed {
    logic off_cyl_fault_ind_n;
    logic rd_wr_fault_ind_n;
    logic no_ac_fault_ind_n;
    logic multi_head_fault_ind_n;
    logic nondestructive_summary_n;
    logic destructive_summary_n;
    logic any_write_fault_n;
    logic fault_lamp_n;
  } indicators_s;

endpackage

/* sim/drive_side_model.sv */
// Drive-side model: read/write and servo conditions chosen by a scenario code
`timescale 1ns/10ps
module drive_side_model
  import write_fault_pkg::*;
(
  // Scenario code from the bench
  input wire logic [2:0] kind_i,
  // Conditions seen by the supervisor
  output monitor_s mon_o
);
  // Field order: write, unsettled, read gate, AC current, head select low, DC current
  always_comb begin
    case (kind_i)
      3'h1: mon_o = 6'h37; // Writing off cylinder
      3'h2: mon_o = 6'h2F; // Read gate while writing
      3'h3: mon_o = 6'h23; // Writing with no AC current
      3'h4: mon_o = 6'h00; // Several heads selected
      3'h5: mon_o = 6'h03; // DC current with no write gate
      3'h6: mon_o = 6'h27; // Clean write
      default: mon_o = 6'h02; // Idle and settled
    endcase
  end
endmodule

/* sim/tb_disc_write_fault_detector.sv */
// Self-checking bench for the read/write fault supervisor
`timescale 1ns/10ps
module tb_disc_write_fault_detector;
  import write_fault_pkg::*;
  logic clk_sys_i = 1'h0;
  logic rst_i = 1'h1;
  logic [2:0] kind = 3'h0;
  logic [2:0] clr = 3'h0; // Power-on start, run switch, clear command
  monitor_s mon;
  indicators_s ind;
  logic [STAT_WIDTH-1:0] stat;
  logic retract;
  int err_count = 0;
  int n_tests = 0;
  // Clock and drive-side model
  always #2.5 clk_sys_i = ~clk_sys_i;
  drive_side_model model (.kind_i(kind), .mon_o(mon));
  disc_write_fault_detector DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .mon_i(mon),
    .power_on_sequence_start_i(clr[2]), .run_switch_run_i(clr[1]),
    .clear_fault_command_i(clr[0]), .ind_o(ind), .fault_status_o(stat),
    .head_retract_request_o(retract));
  // Compare and count
  task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Outputs gathered in one word
  function automatic logic [16:0] obs();
    return {ind, stat, retract};
  endfunction
  // Expected outputs for flops {off_cyl, rd_wr, no_ac, multi_head}
  function automatic logic [16:0] ex(input logic [3:0] f);
    logic nd;
    logic d;
    nd = f[3] | f[2];
    d = f[1] | f[0];
    return {~f, ~nd, ~d, ~(nd | d), ~(nd | d), 2'h0, f[2], f[3], 4'h0, d};
  endfunction
  // One sampled cycle of conditions and clears; they stand until the next step
  task automatic step(input logic [2:0] k, input logic [2:0] c);
    kind = k;
    clr = c;
    @(posedge clk_sys_i);
    #1;
  endtask
  // Each fault kind alone, then cleared by the run switch
  task automatic each_kind;
    logic [3:0] fl [1:6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h3, 4'h0};
    for (int k = 1; k <= 6; k++) begin
      step(3'(k), 3'h0);
      chk("single fault", obs(), ex(fl[k]));
      step(3'h0, 3'h2);
      chk("run clear", obs(), ex(4'h0));
    end
  endtask
  // A latched fault blocks later ones of either class
  task automatic blocking;
    step(3'h1, 3'h0);
    step(3'h4, 3'h0);
    chk("blocked by nd", obs(), ex(4'h8));
    step(3'h0, 3'h1);
    step(3'h4, 3'h0);
    step(3'h2, 3'h0);
    chk("blocked by d", obs(), ex(4'h1));
    step(3'h0, 3'h2);
    chk("run clear after block", obs(), ex(4'h0));
  endtask
  // Command clear spares destructive flops; clears beat sets
  task automatic clears;
    step(3'h1, 3'h1);
    chk("clear beats set", obs(), ex(4'h0));
    step(3'h5, 3'h1);
    step(3'h0, 3'h1);
    chk("cmd keeps d", obs(), ex(4'h3));
    step(3'h3, 3'h4);
    chk("power clear", obs(), ex(4'h0));
    step(3'h2, 3'h0);
    step(3'h0, 3'h4);
    chk("power nd clear", obs(), ex(4'h0));
    step(3'h4, 3'h2);
    chk("run beats set", obs(), ex(4'h0));
  endtask
  // Verdict and end of run
  task automatic print_verdict;
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #100000;
    err_count++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys_i);
    #1;
    rst_i = 1'h0;
    chk("after reset", obs(), ex(4'h0));
    each_kind();
    blocking();
    clears();
    print_verdict();
  end
endmodule
